/* File: hw/rtccal_top.sv */
// Calendar fields of the real-time clock with an AHB-Lite register slave
//
// Contract
// (RULE1) Weekday sits in bits 2..0 counting 0 Sunday to 6 Saturday; upper bits read zero.
// (RULE2) Weekday code 7 means ignore in the alarm page and is not accepted on page 0.
// (RULE3) Day of month sits in bits 5..0 as BCD 01..31; bits 7..6 read zero.
// (RULE4) Day code 3f means ignore in the alarm page and is not accepted on page 0.
// (RULE5) Software never loads a day that does not exist in the current month.
// (RULE6) Month sits in bits 4..0 of the page 0 month register as BCD 01..12; upper bits zero.
// (RULE7) On page 1 the month address holds the hour format in bit 0, 1 meaning 24-hour.
// (RULE8) Software changes the hour format only while counting is stopped.
// (RULE9) Year uses all eight bits of page 0 as BCD 00..99.
// (RULE10) Software writes only listed codes; anything else gives undefined results.
// (RULE11) Month and year exist only on page 0; weekday and day exist on both pages.
// (RULE12) The page 1 year address holds a two-bit leap phase, 0 meaning a leap year.
// (RULE13) A day carry advances weekday and day, wraps at month end, then month and year.
`timescale 1ns/1ps
`include "rtccal_defs.svh"
module rtccal_top
  import rtccal_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Time-of-day side
  input  wire logic        day_carry,
  output logic             hour_24,
  output logic             counting,
  output logic             alarm_date_match
);
  rtccal_if cal ();

  rtccal_bus_e st_r;
  rtccal_bus_e st_nxt;
  logic [5:0]  idx_r;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_r;
  logic        page_r;
  logic        run_r;
  logic [2:0]  wd_r;
  logic [5:0]  day_r;
  logic [4:0]  mon_r;
  logic [7:0]  yr_r;
  logic [1:0]  leap_r;
  logic        fmt_r;
  logic [2:0]  al_wd_r;
  logic [5:0]  al_day_r;
  logic        match_r;
  logic        match_nxt;

  wire         accept  = hsel && htrans[1] && hready;
  wire         wr_now  = (st_r == ST_WR);
  wire         step    = day_carry && run_r;
  wire         wr_ctrl = wr_now && (idx_r == `RTCCAL_IDX_CTRL);
  wire         wr_wd   = wr_now && (idx_r == `RTCCAL_IDX_WEEKDAY);
  wire         wr_day  = wr_now && (idx_r == `RTCCAL_IDX_DAY);
  wire         wr_mon  = wr_now && (idx_r == `RTCCAL_IDX_MONTH);
  wire         wr_yr   = wr_now && (idx_r == `RTCCAL_IDX_YEAR);
  wire         wr_p0   = !page_r;
  // Page 0 refuses the alarm wildcards so the running date stays valid
  wire         ld_wd   = wr_wd && wr_p0 && (hwdata[2:0] != `RTCCAL_WD_ANY); // see (RULE2)
  wire         ld_day  = wr_day && wr_p0 && (hwdata[5:0] != `RTCCAL_DAY_ANY); // see (RULE4)
  wire         ld_awd  = wr_wd && page_r;
  wire         ld_aday = wr_day && page_r;
  wire         ld_mon  = wr_mon && wr_p0; // see (RULE11)
  wire         ld_fmt  = wr_mon && page_r; // see (RULE7)
  wire         ld_yr   = wr_yr && wr_p0; // see (RULE11)
  wire         ld_leap = wr_yr && page_r; // see (RULE12)

  wire [31:0]  rd_ctrl = {30'h0, run_r, page_r};
  wire [31:0]  rd_wd   = {29'h0, page_r ? al_wd_r : wd_r}; // see (RULE1)
  wire [31:0]  rd_day  = {26'h0, page_r ? al_day_r : day_r}; // see (RULE3)
  wire [31:0]  rd_mon  = page_r ? {31'h0, fmt_r} : {27'h0, mon_r}; // see (RULE6)
  wire [31:0]  rd_yr   = page_r ? {30'h0, leap_r} : {24'h0, yr_r}; // see (RULE9)

  assign cal.wd   = wd_r;
  assign cal.day  = day_r;
  assign cal.mon  = mon_r;
  assign cal.yr   = yr_r;
  assign cal.leap = leap_r;

  rtccal_step u_step (
    .cal (cal)
  );

  // Unmapped indices read zero and ignore writes
  assign rd_mux = (idx_r == `RTCCAL_IDX_CTRL)    ? rd_ctrl :
                  (idx_r == `RTCCAL_IDX_WEEKDAY) ? rd_wd :
                  (idx_r == `RTCCAL_IDX_DAY)     ? rd_day :
                  (idx_r == `RTCCAL_IDX_MONTH)   ? rd_mon :
                  (idx_r == `RTCCAL_IDX_YEAR)    ? rd_yr : 32'h0; // see (RULE11)

  // One wait state on reads, so a write just before is always seen
  always_comb
  begin
    st_nxt = ST_IDLE;
    case (st_r)
      ST_RD_WAIT: st_nxt = ST_RD;
      ST_IDLE, ST_WR, ST_RD:
      begin
        if (accept)
          st_nxt = hwrite ? ST_WR : ST_RD_WAIT;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  assign hreadyout        = (st_r != ST_RD_WAIT);
  assign hresp            = 1'b0;
  assign hrdata           = hrdata_r;
  assign hour_24          = fmt_r;
  assign counting         = run_r;
  assign alarm_date_match = match_r;

  // Wildcards in the alarm page match any running value
  assign match_nxt = ((al_wd_r == `RTCCAL_WD_ANY) || (al_wd_r == wd_r)) &&
                     ((al_day_r == `RTCCAL_DAY_ANY) || (al_day_r == day_r)); // see (RULE2) (RULE4)

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r     <= ST_IDLE;
      idx_r    <= 6'h00;
      hrdata_r <= 32'h0;
      match_r  <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (accept)
        idx_r <= (haddr[31:8] == 24'h0) ? haddr[7:2] : 6'h3f;
      if (st_r == ST_RD_WAIT)
        hrdata_r <= rd_mux;
      match_r <= match_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      page_r <= 1'b0;
      run_r  <= 1'b0;
      fmt_r  <= `RTCCAL_RST_FMT;
    end
    else if (wr_ctrl)
    begin
      page_r <= hwdata[`RTCCAL_CTRL_PAGE];
      run_r  <= hwdata[`RTCCAL_CTRL_RUN];
    end
    else if (ld_fmt)
      fmt_r <= hwdata[0]; // see (RULE7)
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      al_wd_r  <= `RTCCAL_RST_AL_WD;
      al_day_r <= `RTCCAL_RST_AL_DAY;
    end
    else
    begin
      if (ld_awd)
        al_wd_r <= hwdata[2:0];
      if (ld_aday)
        al_day_r <= hwdata[5:0];
    end
  end

  // A write to a field wins over a carry in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wd_r   <= `RTCCAL_RST_WD;
      day_r  <= `RTCCAL_RST_DAY;
      mon_r  <= `RTCCAL_RST_MON;
      yr_r   <= `RTCCAL_RST_YEAR;
      leap_r <= `RTCCAL_RST_LEAP;
    end
    else
    begin
      if (ld_wd)
        wd_r <= hwdata[2:0];
      else if (step)
        wd_r <= cal.wd_nxt; // see (RULE13)
      if (ld_day)
        day_r <= hwdata[5:0];
      else if (step)
        day_r <= cal.day_nxt; // see (RULE13)
      if (ld_mon)
        mon_r <= hwdata[4:0];
      else if (step)
        mon_r <= cal.mon_nxt; // see (RULE13)
      if (ld_yr)
        yr_r <= hwdata[7:0];
      else if (step)
        yr_r <= cal.yr_nxt; // see (RULE9)
      if (ld_leap)
        leap_r <= hwdata[1:0];
      else if (step)
        leap_r <= cal.leap_nxt; // see (RULE12)
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // A write in its data phase wins over a carry, so those cycles are left out
  wire quiet_step = step && !wr_now;
  wire rd_sample  = (st_r == ST_RD_WAIT);

  a_weekday_wrap: assert property ( // see (RULE1)
    quiet_step && wd_r == 3'h6 |=> wd_r == 3'h0)
    else $error("weekday did not wrap from Saturday to Sunday");

  a_weekday_read: assert property ( // see (RULE1)
    rd_sample && idx_r == `RTCCAL_IDX_WEEKDAY |=> hrdata[31:3] == 29'h0)
    else $error("weekday upper bits not zero");

  a_page0_wd_refuse: assert property ( // see (RULE2)
    wr_wd && !page_r && hwdata[2:0] == 3'h7 && !step |=> $stable(wd_r))
    else $error("page 0 weekday took code 7");

  a_alarm_wildcard: assert property ( // see (RULE4)
    al_wd_r == 3'h7 && al_day_r == 6'h3f |=> alarm_date_match)
    else $error("wildcard alarm date did not match");

  a_day_read: assert property ( // see (RULE3)
    rd_sample && idx_r == `RTCCAL_IDX_DAY |=> hrdata[31:6] == 26'h0)
    else $error("day upper bits not zero");

  a_month_end: assert property ( // see (RULE13)
    quiet_step && day_r == 6'h30 && mon_r == 5'h04 |=> day_r == 6'h01 && mon_r == 5'h05)
    else $error("April did not end after the thirtieth");

  a_feb_leap: assert property ( // see (RULE13)
    quiet_step && day_r == 6'h28 && mon_r == 5'h02 && leap_r == 2'h0 |=> day_r == 6'h29)
    else $error("leap February skipped the twenty-ninth");

  // A carry may land on the sample edge, so compare with the sampled value
  a_month_read: assert property ( // see (RULE6)
    rd_sample && !page_r && idx_r == `RTCCAL_IDX_MONTH |=> hrdata == {27'h0, $past(mon_r)})
    else $error("month read wrong");

  a_format_read: assert property ( // see (RULE7)
    rd_sample && page_r && idx_r == `RTCCAL_IDX_MONTH |=> hrdata == {31'h0, hour_24})
    else $error("hour format read wrong");

  a_year_wrap: assert property ( // see (RULE9)
    quiet_step && day_r == 6'h31 && mon_r == 5'h12 && yr_r == 8'h99
    |=> yr_r == 8'h00 && mon_r == 5'h01 && leap_r == $past(leap_r) + 2'h1)
    else $error("year or leap phase did not roll over");

  a_leap_read: assert property ( // see (RULE11) (RULE12)
    rd_sample && page_r && idx_r == `RTCCAL_IDX_YEAR |=> hrdata == {30'h0, $past(leap_r)})
    else $error("page 1 year address did not show leap phase");

  a_read_wait: assert property (
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");

  a_page0_day_refuse: assert property ( // see (RULE4)
    wr_day && !page_r && hwdata[5:0] == 6'h3f && !step |=> $stable(day_r))
    else $error("page 0 day took the wildcard code");

  a_feb_plain: assert property ( // see (RULE13)
    quiet_step && day_r == 6'h28 && mon_r == 5'h02 && leap_r != 2'h0
    |=> day_r == 6'h01 && mon_r == 5'h03)
    else $error("common-year February did not end after the twenty-eighth");

  a_stopped_hold: assert property ( // see (RULE13)
    day_carry && !run_r && !wr_now
    |=> $stable(wd_r) && $stable(day_r) && $stable(mon_r) && $stable(yr_r))
    else $error("calendar moved while counting was stopped");

  a_year_read: assert property ( // see (RULE9)
    rd_sample && !page_r && idx_r == `RTCCAL_IDX_YEAR |=> hrdata == {24'h0, $past(yr_r)})
    else $error("year read wrong");

  a_format_out: assert property ( // see (RULE7)
    ld_fmt |=> hour_24 == $past(hwdata[0]))
    else $error("hour format output did not follow the write");

  a_unmapped_read: assert property (
    rd_sample && idx_r > `RTCCAL_IDX_YEAR |=> hrdata == 32'h0)
    else $error("unmapped index did not read zero");

  c_day_step:  cover property (quiet_step ##1 !step);
  c_year_roll: cover property (quiet_step && cal.mon_wrap);
  c_read_back: cover property (accept && !hwrite ##2 hreadyout);
  c_alarm_hit: cover property (!alarm_date_match ##1 alarm_date_match);
  c_month_end: cover property (quiet_step && cal.day_wrap && !cal.mon_wrap);
endmodule : rtccal_top

/* File: inc/rtccal_defs.svh */
// Register offsets, field codes and reset values of the calendar block
`ifndef RTCCAL_DEFS_SVH
`define RTCCAL_DEFS_SVH

`define RTCCAL_IDX_CTRL     6'h00
`define RTCCAL_IDX_WEEKDAY  6'h01
`define RTCCAL_IDX_DAY      6'h02
`define RTCCAL_IDX_MONTH    6'h03
`define RTCCAL_IDX_YEAR     6'h04

`define RTCCAL_CTRL_PAGE    0
`define RTCCAL_CTRL_RUN     1

`define RTCCAL_WD_LAST      3'h6
`define RTCCAL_WD_ANY       3'h7
`define RTCCAL_DAY_FIRST    6'h01
`define RTCCAL_DAY_ANY      6'h3f
`define RTCCAL_MON_FIRST    5'h01
`define RTCCAL_MON_LAST     5'h12
`define RTCCAL_YEAR_LAST    8'h99

`define RTCCAL_RST_WD       3'h0
`define RTCCAL_RST_DAY      6'h01
`define RTCCAL_RST_MON      5'h01
`define RTCCAL_RST_YEAR     8'h00
`define RTCCAL_RST_LEAP     2'h0
`define RTCCAL_RST_FMT      1'h1
`define RTCCAL_RST_AL_WD    3'h7
`define RTCCAL_RST_AL_DAY   6'h3f

`endif

/* File: inc/rtccal_pkg.sv */
// Types shared by the calendar block
package rtccal_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WR,
    ST_RD_WAIT,
    ST_RD
  } rtccal_bus_e;
endpackage : rtccal_pkg

/* File: inc/rtccal_if.sv */
// Current and next calendar values between register file and stepper
`timescale 1ns/1ps
interface rtccal_if;
  logic [2:0] wd;
  logic [5:0] day;
  logic [4:0] mon;
  logic [7:0] yr;
  logic [1:0] leap;
  logic [2:0] wd_nxt;
  logic [5:0] day_nxt;
  logic [4:0] mon_nxt;
  logic [7:0] yr_nxt;
  logic [1:0] leap_nxt;
  logic       day_wrap;
  logic       mon_wrap;

  modport calc  (input wd, day, mon, yr, leap,
                 output wd_nxt, day_nxt, mon_nxt, yr_nxt, leap_nxt, day_wrap, mon_wrap);
  modport owner (output wd, day, mon, yr, leap,
                 input wd_nxt, day_nxt, mon_nxt, yr_nxt, leap_nxt, day_wrap, mon_wrap);
endinterface : rtccal_if

/* File: hw/rtccal_step.sv */
// Next calendar values for one day carry
`timescale 1ns/1ps
`include "rtccal_defs.svh"
module rtccal_step
  import rtccal_pkg::*;
(
  // Calendar values
  rtccal_if.calc cal
);
  function automatic logic [7:0] rtccal_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      rtccal_bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      rtccal_bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : rtccal_bcd_inc

  logic [5:0] last_day;
  logic [7:0] day_inc;
  logic [7:0] mon_inc;
  logic       yr_wrap;

  // February follows the leap phase
  assign last_day = (cal.mon == 5'h02) ? ((cal.leap == 2'h0) ? 6'h29 : 6'h28) :
                    (cal.mon == 5'h04 || cal.mon == 5'h06 ||
                     cal.mon == 5'h09 || cal.mon == 5'h11) ? 6'h30 : 6'h31; // see (RULE13)
  assign day_inc      = rtccal_bcd_inc({2'h0, cal.day});
  assign mon_inc      = rtccal_bcd_inc({3'h0, cal.mon});
  assign cal.day_wrap = (cal.day == last_day);
  assign cal.mon_wrap = cal.day_wrap && (cal.mon == `RTCCAL_MON_LAST);
  assign yr_wrap      = (cal.yr == `RTCCAL_YEAR_LAST);
  assign cal.wd_nxt   = (cal.wd == `RTCCAL_WD_LAST) ? 3'h0 : cal.wd + 3'h1; // see (RULE1)
  assign cal.day_nxt  = cal.day_wrap ? `RTCCAL_DAY_FIRST : day_inc[5:0]; // see (RULE13)
  assign cal.mon_nxt  = !cal.day_wrap ? cal.mon :
                        cal.mon_wrap ? `RTCCAL_MON_FIRST : mon_inc[4:0]; // see (RULE13)
  assign cal.yr_nxt   = !cal.mon_wrap ? cal.yr :
                        yr_wrap ? 8'h00 : rtccal_bcd_inc(cal.yr); // see (RULE9)
  assign cal.leap_nxt = cal.mon_wrap ? cal.leap + 2'h1 : cal.leap; // see (RULE12)
endmodule : rtccal_step

/* File: test/tb_top.sv */
// Self-checking bench for the calendar register block
`timescale 1ns/1ps
`include "rtccal_defs.svh"
module tb_top
  import rtccal_pkg::*;
;
  localparam logic [31:0] A_CTRL = {24'h0, `RTCCAL_IDX_CTRL, 2'b00};
  localparam logic [31:0] A_WD   = {24'h0, `RTCCAL_IDX_WEEKDAY, 2'b00};
  localparam logic [31:0] A_DAY  = {24'h0, `RTCCAL_IDX_DAY, 2'b00};
  localparam logic [31:0] A_MON  = {24'h0, `RTCCAL_IDX_MONTH, 2'b00};
  localparam logic [31:0] A_YR   = {24'h0, `RTCCAL_IDX_YEAR, 2'b00};

  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} rtccal_row_s;

  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0;
  logic        day_carry = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic        hour_24;
  logic        counting;
  logic        alarm_date_match;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int          n_fail     = 0;
  int          n_compared = 0;
  int          n_wait     = 0;

  // Page 0 fields first, then page 1 through the control register
  rtccal_row_s rows [16] = '{
    '{A_WD, 32'h06, 32'h06}, '{A_WD, 32'hfb, 32'h03},
    '{A_DAY, 32'h31, 32'h31}, '{A_DAY, 32'hd5, 32'h15},
    '{A_MON, 32'h12, 32'h12}, '{A_MON, 32'he9, 32'h09},
    '{A_YR, 32'h99, 32'h99}, '{A_YR, 32'h00, 32'h00},
    '{A_CTRL, 32'h01, 32'h01}, '{A_WD, 32'h07, 32'h07},
    '{A_DAY, 32'h3f, 32'h3f}, '{A_MON, 32'hfe, 32'h00},
    '{A_YR, 32'hff, 32'h03}, '{A_MON, 32'h01, 32'h01},
    '{32'h20, 32'hffffffff, 32'h0}, '{A_CTRL, 32'h00, 32'h00}
  };

  always #5 hclk = ~hclk;

  rtccal_top dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .day_carry        (day_carry),
    .hour_24          (hour_24),
    .counting         (counting),
    .alarm_date_match (alarm_date_match)
  );

  task end_of_test();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // Address phase held until hready, then data phase until hready again
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    n_wait = 0;
    do
    begin
      @(posedge hclk);
      n_wait++;
    end
    while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task rd_chk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk_word(rd, e);
    chk_word(n_wait, 32'h2);
  endtask : rd_chk

  task carry();
    day_carry <= 1'b1;
    @(posedge hclk);
    day_carry <= 1'b0;
    @(posedge hclk);
  endtask : carry

  task reset_dut();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : reset_dut

  initial
  begin
    reset_dut();
    chk_bit(hour_24, 1'b1);
    chk_bit(counting, 1'b0);
    chk_bit(hresp, 1'b0);
    rd_chk(A_WD, 32'h00);
    rd_chk(A_DAY, 32'h01);
    rd_chk(A_MON, 32'h01);
    rd_chk(A_YR, 32'h00);
    chk_bit(alarm_date_match, 1'b1);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    rd_chk(A_MON, 32'h09);
    rd_chk(A_YR, 32'h00);
    wr(A_WD, 32'h07);
    rd_chk(A_WD, 32'h03);
    wr(A_DAY, 32'h3f);
    rd_chk(A_DAY, 32'h15);
    // Alarm weekday against running weekday 3, day left as wildcard
    wr(A_CTRL, 32'h01);
    wr(A_WD, 32'h05);
    repeat (2) @(posedge hclk);
    chk_bit(alarm_date_match, 1'b0);
    wr(A_WD, 32'h03);
    repeat (2) @(posedge hclk);
    chk_bit(alarm_date_match, 1'b1);
    // Format is written while counting is stopped
    wr(A_MON, 32'h00);
    @(posedge hclk);
    chk_bit(hour_24, 1'b0);
    wr(A_MON, 32'h01);
    @(posedge hclk);
    chk_bit(hour_24, 1'b1);
    // Year end with leap phase 3; a carry while stopped must not count
    wr(A_CTRL, 32'h00);
    wr(A_WD, 32'h06);
    wr(A_MON, 32'h12);
    wr(A_DAY, 32'h31);
    wr(A_YR, 32'h99);
    carry();
    rd_chk(A_DAY, 32'h31);
    wr(A_CTRL, 32'h02);
    @(posedge hclk);
    chk_bit(counting, 1'b1);
    carry();
    rd_chk(A_WD, 32'h00);
    rd_chk(A_DAY, 32'h01);
    rd_chk(A_MON, 32'h01);
    rd_chk(A_YR, 32'h00);
    wr(A_CTRL, 32'h03);
    rd_chk(A_YR, 32'h00);
    // Leap year: February runs to the 29th
    wr(A_CTRL, 32'h02);
    wr(A_MON, 32'h02);
    wr(A_DAY, 32'h28);
    carry();
    rd_chk(A_DAY, 32'h29);
    carry();
    rd_chk(A_DAY, 32'h01);
    rd_chk(A_MON, 32'h03);
    rd_chk(A_WD, 32'h02);
    // Thirty-day months, the second one with a month digit carry
    wr(A_MON, 32'h04);
    wr(A_DAY, 32'h30);
    carry();
    rd_chk(A_DAY, 32'h01);
    rd_chk(A_MON, 32'h05);
    wr(A_MON, 32'h09);
    wr(A_DAY, 32'h30);
    carry();
    rd_chk(A_DAY, 32'h01);
    rd_chk(A_MON, 32'h10);
    // One year after a leap year February ends on the 28th
    wr(A_CTRL, 32'h03);
    wr(A_YR, 32'h01);
    rd_chk(A_YR, 32'h01);
    wr(A_CTRL, 32'h02);
    wr(A_MON, 32'h02);
    wr(A_DAY, 32'h28);
    carry();
    rd_chk(A_DAY, 32'h01);
    rd_chk(A_MON, 32'h03);
    rd_chk(A_WD, 32'h05);
    reset_dut();
    chk_bit(counting, 1'b0);
    rd_chk(A_DAY, 32'h01);
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    end_of_test();
  end
endmodule : tb_top
